/* File: cse_consts.vh */
// Constants for the configuration status export block.
// Assumes the includer runs on the application-layer clock.
`ifndef CSE_CONSTS_VH
`define CSE_CONSTS_VH

// Function count and field widths
`define CSE_NUM_PF 4
`define CSE_BUS_W 8
`define CSE_DEV_W 5
`define CSE_REG_W 16
`define CSE_SIZE_W 3
`define CSE_STM_W 2
`define CSE_STU_W 5
`define CSE_SEL_W 3

// Configuration register selects on the write port
`define CSE_SEL_COMMAND 3'h0
`define CSE_SEL_DEVCTL 3'h1
`define CSE_SEL_DEVCTL2 3'h2
`define CSE_SEL_SRIOV_CTL 3'h3
`define CSE_SEL_VIRTUAL_FUNCTION_COUNT_FIELD 3'h4
`define CSE_SEL_TPH_CTL 3'h5
`define CSE_SEL_ATS_CTL 3'h6

// Field positions
`define CSE_CMD_MEM_BIT 1
`define CSE_CMD_MASTER_BIT 2
`define CSE_DC_PAYLOAD_LSB 5
`define CSE_DC_WIDE_TAG_BIT 8
`define CSE_DC_RDREQ_LSB 12
`define CSE_DC2_CTO_OFF_BIT 4
`define CSE_DC2_ATOMIC_BIT 6
`define CSE_SRIOV_VF_MEM_BIT 3
`define CSE_TPH_MODE_LSB 0
`define CSE_TPH_EN_BIT 8
`define CSE_ATS_STU_LSB 0
`define CSE_ATS_EN_BIT 15

// Reset values
`define CSE_RST_REG 16'h0000
`define CSE_RST_DEVCTL 16'h2000
`define CSE_RST_BUS 8'h00
`define CSE_RST_DEV 5'h00

// Cycles from a configuration write to the exported value
`define CSE_UPDATE_LATENCY 2

`endif

/* File: cse_pf_regs.v */
// Holds the shadowed configuration registers of one physical function.
// Assumes writes arrive as single-cycle strobes from logic on sys_clk.
`include "cse_consts.vh"
`default_nettype none

module cse_pf_regs (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Configuration write strobe
  input wire wr_en,
  input wire [`CSE_SEL_W-1:0] wr_sel,
  input wire [`CSE_REG_W-1:0] wr_data,
  input wire [`CSE_BUS_W-1:0] wr_bus,
  input wire [`CSE_DEV_W-1:0] wr_dev,
  // Stored values
  output reg [`CSE_BUS_W-1:0] bus_number_r,
  output reg [`CSE_DEV_W-1:0] device_number_r,
  output reg [`CSE_REG_W-1:0] command_r,
  output reg [`CSE_REG_W-1:0] devctl_r,
  output reg [`CSE_REG_W-1:0] devctl2_r,
  output reg [`CSE_REG_W-1:0] sriov_ctl_r,
  output reg [`CSE_REG_W-1:0] virtual_function_count_field_r,
  output reg [`CSE_REG_W-1:0] tph_ctl_r,
  output reg [`CSE_REG_W-1:0] ats_ctl_r
);

  // Any write to the function also captures its routing identity
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_number_r <= `CSE_RST_BUS;
      device_number_r <= `CSE_RST_DEV;
      command_r <= `CSE_RST_REG;
      devctl_r <= `CSE_RST_DEVCTL;
      devctl2_r <= `CSE_RST_REG;
      sriov_ctl_r <= `CSE_RST_REG;
      virtual_function_count_field_r <= `CSE_RST_REG;
      tph_ctl_r <= `CSE_RST_REG;
      ats_ctl_r <= `CSE_RST_REG;
    end
    else if (wr_en)
    begin
      bus_number_r <= wr_bus;
      device_number_r <= wr_dev;
      case (wr_sel)
        `CSE_SEL_COMMAND: command_r <= wr_data;
        `CSE_SEL_DEVCTL: devctl_r <= wr_data;
        `CSE_SEL_DEVCTL2: devctl2_r <= wr_data;
        `CSE_SEL_SRIOV_CTL: sriov_ctl_r <= wr_data;
        `CSE_SEL_VIRTUAL_FUNCTION_COUNT_FIELD: virtual_function_count_field_r <= wr_data;
        `CSE_SEL_TPH_CTL: tph_ctl_r <= wr_data;
        `CSE_SEL_ATS_CTL: ats_ctl_r <= wr_data;
        default: command_r <= command_r; // Unused select ignored
      endcase
    end
  end

endmodule // cse_pf_regs

`default_nettype wire

/* File: cse_config_status.v */
// Exports configuration-space settings of each physical function as
// parallel status outputs for the application layer.
// Assumes the configuration write port is driven from logic on sys_clk,
// so it is taken without synchronisers.
`include "cse_consts.vh"
`default_nettype none

module cse_config_status (
  // Application-layer clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Functions present; function 0 always counts as present
  input wire [`CSE_NUM_PF-1:0] pf_enabled,
  // Alternative routing in force
  input wire alternative_routing_id,
  // Configuration write port
  input wire cfg_wr_valid,
  input wire [1:0] cfg_wr_func,
  input wire [`CSE_SEL_W-1:0] cfg_wr_sel,
  input wire [`CSE_REG_W-1:0] cfg_wr_data,
  input wire [`CSE_BUS_W-1:0] cfg_wr_bus,
  input wire [`CSE_DEV_W-1:0] cfg_wr_dev,
  // Routing identity per function
  output reg [`CSE_NUM_PF*`CSE_BUS_W-1:0] pf_bus_number,
  output reg [`CSE_NUM_PF*`CSE_DEV_W-1:0] pf_device_number,
  output reg device_number_in_use,
  // Command and SR-IOV enables, plus the virtual function count field
  output reg [`CSE_NUM_PF-1:0] pf_memory_space_enable,
  output reg [`CSE_NUM_PF-1:0] pf_master_enable,
  output reg [`CSE_NUM_PF-1:0] vf_memory_space_enable,
  output reg [`CSE_NUM_PF*`CSE_REG_W-1:0] virtual_function_count_field,
  // Device control derived settings
  output reg [`CSE_SIZE_W-1:0] max_payload_size,
  output reg [`CSE_SIZE_W-1:0] max_read_request_size,
  output reg [`CSE_NUM_PF-1:0] wide_tag_enable,
  output reg [`CSE_NUM_PF-1:0] completion_timer_off,
  output reg [`CSE_NUM_PF-1:0] atomic_requester_enable,
  // Processing hints and translation service
  output reg [`CSE_NUM_PF*`CSE_STM_W-1:0] steering_tag_mode,
  output reg [`CSE_NUM_PF-1:0] hint_requester_enable,
  output reg [`CSE_NUM_PF*`CSE_STU_W-1:0] translation_unit_size,
  output reg [`CSE_NUM_PF-1:0] translation_service_enable
);

  // Effective presence: function 0 is always there
  wire [`CSE_NUM_PF-1:0] present;
  assign present = {pf_enabled[`CSE_NUM_PF-1:1], 1'b1};

  // Only function 0 present selects the plain path for the size fields
  wire only_pf0;
  assign only_pf0 = ~|pf_enabled[`CSE_NUM_PF-1:1];

  // Packed next values, built per function below
  wire [`CSE_NUM_PF*`CSE_BUS_W-1:0] bus_nxt;
  wire [`CSE_NUM_PF*`CSE_DEV_W-1:0] dev_nxt;
  wire [`CSE_NUM_PF-1:0] mem_nxt;
  wire [`CSE_NUM_PF-1:0] master_nxt;
  wire [`CSE_NUM_PF-1:0] vf_mem_nxt;
  wire [`CSE_NUM_PF*`CSE_REG_W-1:0] virtual_function_count_field_nxt;
  wire [`CSE_NUM_PF*`CSE_SIZE_W-1:0] payload_all;
  wire [`CSE_NUM_PF*`CSE_SIZE_W-1:0] rdreq_all;
  wire [`CSE_NUM_PF-1:0] wide_tag_nxt;
  wire [`CSE_NUM_PF-1:0] cto_off_nxt;
  wire [`CSE_NUM_PF-1:0] atomic_nxt;
  wire [`CSE_NUM_PF*`CSE_STM_W-1:0] stm_nxt;
  wire [`CSE_NUM_PF-1:0] hint_nxt;
  wire [`CSE_NUM_PF*`CSE_STU_W-1:0] stu_nxt;
  wire [`CSE_NUM_PF-1:0] ats_nxt;

  // One register store per function, plus field extraction
  genvar g;
  generate
    for (g = 0; g < `CSE_NUM_PF; g = g + 1)
    begin : pf_gen
      wire [`CSE_REG_W-1:0] cmd;
      wire [`CSE_REG_W-1:0] dc;
      wire [`CSE_REG_W-1:0] dc2;
      wire [`CSE_REG_W-1:0] sriov;
      wire [`CSE_REG_W-1:0] tph;
      wire [`CSE_REG_W-1:0] ats;
      wire wr_hit;

      // Writes to an absent function are dropped
      assign wr_hit = cfg_wr_valid & (cfg_wr_func == g) & present[g];

      cse_pf_regs u_regs (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr_en(wr_hit),
        .wr_sel(cfg_wr_sel),
        .wr_data(cfg_wr_data),
        .wr_bus(cfg_wr_bus),
        .wr_dev(cfg_wr_dev),
        .bus_number_r(bus_nxt[g*`CSE_BUS_W +: `CSE_BUS_W]),
        .device_number_r(dev_nxt[g*`CSE_DEV_W +: `CSE_DEV_W]),
        .command_r(cmd),
        .devctl_r(dc),
        .devctl2_r(dc2),
        .sriov_ctl_r(sriov),
        .virtual_function_count_field_r(virtual_function_count_field_nxt[g*`CSE_REG_W +: `CSE_REG_W]),
        .tph_ctl_r(tph),
        .ats_ctl_r(ats)
      );

      // Command register and SR-IOV control enables
      assign mem_nxt[g] = cmd[`CSE_CMD_MEM_BIT];
      assign master_nxt[g] = cmd[`CSE_CMD_MASTER_BIT];
      assign vf_mem_nxt[g] = sriov[`CSE_SRIOV_VF_MEM_BIT];

      // Device control and device control 2 fields
      assign payload_all[g*`CSE_SIZE_W +: `CSE_SIZE_W] =
        dc[`CSE_DC_PAYLOAD_LSB +: `CSE_SIZE_W];
      assign rdreq_all[g*`CSE_SIZE_W +: `CSE_SIZE_W] =
        dc[`CSE_DC_RDREQ_LSB +: `CSE_SIZE_W];
      assign wide_tag_nxt[g] = dc[`CSE_DC_WIDE_TAG_BIT];
      assign cto_off_nxt[g] = dc2[`CSE_DC2_CTO_OFF_BIT];
      assign atomic_nxt[g] = dc2[`CSE_DC2_ATOMIC_BIT];

      // Processing hints, packed two bits per function
      assign stm_nxt[g*`CSE_STM_W +: `CSE_STM_W] =
        tph[`CSE_TPH_MODE_LSB +: `CSE_STM_W];
      assign hint_nxt[g] = tph[`CSE_TPH_EN_BIT];

      // Translation service, packed five bits per function
      assign stu_nxt[g*`CSE_STU_W +: `CSE_STU_W] =
        ats[`CSE_ATS_STU_LSB +: `CSE_STU_W];
      assign ats_nxt[g] = ats[`CSE_ATS_EN_BIT];
    end
  endgenerate

  // Smallest size field among present functions; absent ones are skipped
  // so a stale value in an unused store cannot shrink the limit.
  function [`CSE_SIZE_W-1:0] min_present;
    input [`CSE_NUM_PF*`CSE_SIZE_W-1:0] fields;
    input [`CSE_NUM_PF-1:0] pres;
    integer i;
    reg [`CSE_SIZE_W-1:0] cur;
    reg [`CSE_SIZE_W-1:0] best;
    begin
      best = fields[`CSE_SIZE_W-1:0];
      for (i = 1; i < `CSE_NUM_PF; i = i + 1)
      begin
        cur = fields[i*`CSE_SIZE_W +: `CSE_SIZE_W];
        if (pres[i] && (cur < best))
          best = cur;
      end
      min_present = best;
    end
  endfunction

  // Reset view of device control, sliced so the size fields keep their width
  localparam [`CSE_REG_W-1:0] devctl_rst = `CSE_RST_DEVCTL;

  // Size outputs: plain function 0 value or the minimum
  reg [`CSE_SIZE_W-1:0] payload_nxt;
  reg [`CSE_SIZE_W-1:0] rdreq_nxt;
  always @*
  begin
    if (only_pf0)
    begin
      payload_nxt = payload_all[`CSE_SIZE_W-1:0];
      rdreq_nxt = rdreq_all[`CSE_SIZE_W-1:0];
    end
    else
    begin
      payload_nxt = min_present(payload_all, present);
      rdreq_nxt = min_present(rdreq_all, present);
    end
  end

  // Output stage: every export but device_number_in_use is a flop one cycle behind the store,
  // giving a fixed two-cycle write-to-output latency and steady values.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pf_bus_number <= {`CSE_NUM_PF{`CSE_RST_BUS}};
      pf_device_number <= {`CSE_NUM_PF{`CSE_RST_DEV}};
      device_number_in_use <= 1'b1;
      pf_memory_space_enable <= {`CSE_NUM_PF{1'b0}};
      pf_master_enable <= {`CSE_NUM_PF{1'b0}};
      vf_memory_space_enable <= {`CSE_NUM_PF{1'b0}};
      virtual_function_count_field <= {`CSE_NUM_PF{`CSE_RST_REG}};
      max_payload_size <= devctl_rst[`CSE_DC_PAYLOAD_LSB +: `CSE_SIZE_W];
      max_read_request_size <= devctl_rst[`CSE_DC_RDREQ_LSB +: `CSE_SIZE_W];
      wide_tag_enable <= {`CSE_NUM_PF{1'b0}};
      completion_timer_off <= {`CSE_NUM_PF{1'b0}};
      atomic_requester_enable <= {`CSE_NUM_PF{1'b0}};
      steering_tag_mode <= {`CSE_NUM_PF*`CSE_STM_W{1'b0}};
      hint_requester_enable <= {`CSE_NUM_PF{1'b0}};
      translation_unit_size <= {`CSE_NUM_PF*`CSE_STU_W{1'b0}};
      translation_service_enable <= {`CSE_NUM_PF{1'b0}};
    end
    else
    begin
      // Informational only; copied from each function's store one cycle later
      pf_bus_number <= bus_nxt;
      pf_device_number <= dev_nxt;
      // Flags the device number as meaningless under alternative routing
      device_number_in_use <= ~alternative_routing_id;
      pf_memory_space_enable <= mem_nxt;
      pf_master_enable <= master_nxt;
      vf_memory_space_enable <= vf_mem_nxt;
      virtual_function_count_field <= virtual_function_count_field_nxt;
      max_payload_size <= payload_nxt;
      max_read_request_size <= rdreq_nxt;
      wide_tag_enable <= wide_tag_nxt;
      completion_timer_off <= cto_off_nxt;
      atomic_requester_enable <= atomic_nxt;
      steering_tag_mode <= stm_nxt;
      hint_requester_enable <= hint_nxt;
      translation_unit_size <= stu_nxt;
      translation_service_enable <= ats_nxt;
    end
  end

endmodule // cse_config_status

`default_nettype wire

/* File: cse_config_status_sva.sv */
// Concurrent checks on the configuration status export block.
// Bound to the top module, sees only its ports, single clock domain.
`default_nettype none
module cse_config_status_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Write side
  input wire logic [3:0] pf_enabled,
  input wire logic alternative_routing_id,
  input wire logic cfg_wr_valid,
  input wire logic [1:0] cfg_wr_func,
  input wire logic [2:0] cfg_wr_sel,
  input wire logic [15:0] cfg_wr_data,
  input wire logic [7:0] cfg_wr_bus,
  // Status side
  input wire logic [31:0] pf_bus_number,
  input wire logic device_number_in_use,
  input wire logic [3:0] pf_memory_space_enable,
  input wire logic [3:0] pf_master_enable,
  input wire logic [2:0] max_payload_size,
  input wire logic [3:0] wide_tag_enable,
  input wire logic [3:0] translation_service_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Function 0 writes are never refused, so they make clean triggers
  wire w0 = cfg_wr_valid && cfg_wr_func == 2'h0;
  a_bus_capture: assert property (w0 |-> ##2 pf_bus_number[7:0] == $past(cfg_wr_bus, 2))
    else $error("bus number not captured");
  a_mem_follow: assert property (w0 && cfg_wr_sel == 3'h0 |-> ##2
    pf_memory_space_enable[0] == $past(cfg_wr_data[1], 2)) else $error("memory enable wrong");
  a_master_follow: assert property (w0 && cfg_wr_sel == 3'h0 |-> ##2
    pf_master_enable[0] == $past(cfg_wr_data[2], 2)) else $error("master enable wrong");
  a_wide_tag: assert property (w0 && cfg_wr_sel == 3'h1 |-> ##2
    wide_tag_enable[0] == $past(cfg_wr_data[8], 2)) else $error("wide tag wrong");
  a_ats_enable: assert property (w0 && cfg_wr_sel == 3'h6 |-> ##2
    translation_service_enable[0] == $past(cfg_wr_data[15], 2)) else $error("ats enable wrong");
  a_dev_in_use: assert property ($past(rst_n) |->
    device_number_in_use == !$past(alternative_routing_id)) else $error("device use wrong");
  a_payload_single: assert property (
    (w0 && cfg_wr_sel == 3'h1 && pf_enabled[3:1] == 3'h0) ##1 (pf_enabled[3:1] == 3'h0) [*2]
    |-> max_payload_size == $past(cfg_wr_data[7:5], 2)) else $error("payload size wrong");
  a_enable_hold: assert property (!cfg_wr_valid |-> ##2 $stable(pf_master_enable))
    else $error("master enable moved without a write");
  // Main scenarios reached
  c_refused: cover property (cfg_wr_valid && cfg_wr_func != 2'h0 && !pf_enabled[cfg_wr_func]);
  c_back_to_back: cover property (cfg_wr_valid ##1 cfg_wr_valid);
  c_single_pf: cover property (w0 && cfg_wr_sel == 3'h1 && pf_enabled[3:1] == 3'h0);
endmodule // cse_config_status_sva

bind cse_config_status cse_config_status_sva cse_config_status_sva_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .pf_enabled(pf_enabled),
  .alternative_routing_id(alternative_routing_id), .cfg_wr_valid(cfg_wr_valid),
  .cfg_wr_func(cfg_wr_func), .cfg_wr_sel(cfg_wr_sel), .cfg_wr_data(cfg_wr_data),
  .cfg_wr_bus(cfg_wr_bus), .pf_bus_number(pf_bus_number),
  .device_number_in_use(device_number_in_use), .pf_master_enable(pf_master_enable),
  .pf_memory_space_enable(pf_memory_space_enable), .max_payload_size(max_payload_size),
  .wide_tag_enable(wide_tag_enable), .translation_service_enable(translation_service_enable));
`default_nettype wire

/* File: cse_app_model.sv */
// Application-side model that forms a requester identity from the status.
// Assumes it shares sys_clk and rst_n with the status block.
`default_nettype none
module cse_app_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Status from the block
  input wire logic [31:0] pf_bus_number,
  input wire logic [19:0] pf_device_number,
  input wire logic device_number_in_use,
  input wire logic [3:0] pf_master_enable,
  // Requesting function and identity
  input wire logic [1:0] req_func,
  output var logic [12:0] req_id_r
);
  // Identity only for reference; it updates only while the function may master
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      req_id_r <= 13'h0000;
    else if (pf_master_enable[req_func])
      req_id_r <= {pf_bus_number[8*req_func+:8],
        device_number_in_use ? pf_device_number[5*req_func+:5] : 5'h00};
  end
endmodule // cse_app_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the configuration status export block.
// Drives writes at the falling edge and compares with an array model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, rst_n = 1'h0, alt = 1'h0, vld = 1'h0;
  logic [3:0] pen = 4'h0;
  logic [1:0] fn = 2'h0;
  logic [2:0] sel = 3'h0;
  logic [15:0] dat = 16'h0000;
  logic [7:0] wb = 8'h00;
  logic [4:0] wd = 5'h00;
  wire [31:0] bus_o;
  wire [19:0] dev_o, stu_o;
  wire [63:0] nvf_o;
  wire [3:0] mse, bme, vme, wte, cto, are, hre, tse;
  wire [2:0] mps, mrr;
  wire [7:0] stm;
  wire diu;
  wire [12:0] rid;
  int fails = 0, checks = 0, cyc = 0;
  int m[4][8], mb[4], md[4];
  cse_config_status cse_config_status_i (.sys_clk(sys_clk), .rst_n(rst_n), .pf_enabled(pen),
    .alternative_routing_id(alt), .cfg_wr_valid(vld), .cfg_wr_func(fn), .cfg_wr_sel(sel),
    .cfg_wr_data(dat), .cfg_wr_bus(wb), .cfg_wr_dev(wd), .pf_bus_number(bus_o),
    .pf_device_number(dev_o), .device_number_in_use(diu), .pf_memory_space_enable(mse),
    .pf_master_enable(bme), .vf_memory_space_enable(vme), .virtual_function_count_field(nvf_o),
    .max_payload_size(mps), .max_read_request_size(mrr), .wide_tag_enable(wte),
    .completion_timer_off(cto), .atomic_requester_enable(are), .steering_tag_mode(stm),
    .hint_requester_enable(hre), .translation_unit_size(stu_o), .translation_service_enable(tse));
  cse_app_model cse_app_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .pf_bus_number(bus_o),
    .pf_device_number(dev_o), .device_number_in_use(diu), .pf_master_enable(bme),
    .req_func(fn), .req_id_r(rid));
  // 100 MHz clock
  initial
    forever #5 sys_clk = ~sys_clk;
  task summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Model restarts from register defaults, read request field at 2
  task apply_reset;
    rst_n = 1'h0;
    foreach (m[f, s])
      m[f][s] = (s == 1) ? 32'h2000 : 0;
    foreach (mb[f])
    begin
      mb[f] = 0;
      md[f] = 0;
    end
    repeat (4) @(negedge sys_clk);
    rst_n = 1'h1;
  endtask
  // One random write; absent functions are refused, select 7 only moves bus/device
  task wr;
    @(negedge sys_clk);
    vld = 1'h1;
    dat = 16'($urandom);
    {wb, wd, fn, sel} = 18'($urandom);
    if (fn == 2'h0 || pen[fn])
    begin
      mb[fn] = wb;
      md[fn] = wd;
      m[fn][sel] = dat;
    end
  endtask
  // Build every expected vector, sizes as minimum over present functions
  task chk_all;
    logic [63:0] eb, ed, en, ec, ez, et, ea;
    int mp, mr;
    {eb, ed, en, ec, ez, et, ea} = '0;
    mp = m[0][1] >> 5 & 7;
    mr = m[0][1] >> 12 & 7;
    for (int n = 0; n < 4; n++)
    begin
      eb[8*n+:8] = 8'(mb[n]);
      ed[5*n+:5] = 5'(md[n]);
      en[16*n+:16] = 16'(m[n][4]);
      {ec[n+8], ec[n+4], ec[n]} = {m[n][3][3], m[n][0][2], m[n][0][1]};
      {ez[n+8], ez[n+4], ez[n]} = {m[n][2][6], m[n][2][4], m[n][1][8]};
      {et[n+8], et[2*n+:2]} = {m[n][5][8], m[n][5][1:0]};
      {ea[n+20], ea[5*n+:5]} = {m[n][6][15], m[n][6][4:0]};
      if (pen[n] && (m[n][1] >> 5 & 7) < mp)
        mp = m[n][1] >> 5 & 7;
      if (pen[n] && (m[n][1] >> 12 & 7) < mr)
        mr = m[n][1] >> 12 & 7;
    end
    chk("bus", bus_o, eb);
    chk("dev", dev_o, ed);
    chk("dev_use", diu, !alt);
    chk("cmd", {vme, bme, mse}, ec);
    chk("virtual_function_count_field", nvf_o, en);
    chk("sizes", {mrr, mps}, mr * 8 + mp);
    chk("devctl", {are, cto, wte}, ez);
    chk("tph", {hre, stm}, et);
    chk("ats", {tse, stu_o}, ea);
    // Requester identity only refreshes while the function may master
    if (ec[fn+4])
      chk("req_id", rid, {eb[8*fn+:8], alt ? 5'h00 : ed[5*fn+:5]});
  endtask
  // Bursts of back-to-back writes, then settle and compare
  initial
  begin
    void'($urandom(32'h4b3a8a22));
    apply_reset;
    repeat (2) @(negedge sys_clk);
    chk_all;
    for (int i = 0; i < 300; i++)
    begin
      repeat (1 + $urandom % 4) wr;
      @(negedge sys_clk);
      vld = 1'h0;
      pen = 4'($urandom);
      alt = 1'($urandom);
      if (i == 150)
        apply_reset;
      repeat (2) @(negedge sys_clk);
      chk_all;
    end
    summarize;
  end
  // Hang guard; the run needs about 1700 cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      summarize;
    end
  end
endmodule // tb
`default_nettype wire
